// >>> hms_sequencer.sv
// Homing method sequencer for the stepper drive
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// RULE_01: Accept methods 17 to 30 and 35
// RULE_02: Method 17 references the negative limit
// RULE_03: Method 18 references the positive limit
// RULE_04: Methods 19-22 home switch only, set start direction
// RULE_05: Methods 19, 21 stop on switch falling edge
// RULE_06: Methods 20, 22 stop on switch rising edge
// RULE_07: Methods 23-26 start positive, use positive limit
// RULE_08: Methods 23-26 reverse at positive limit
// RULE_09: Methods 27-30 start negative, use negative limit
// RULE_10: Methods 27-30 reverse at negative limit
// RULE_11: Methods 23, 30 stop falling edge moving negative
// RULE_12: Methods 24, 29 stop rising edge moving positive
// RULE_13: Methods 25, 28 stop rising edge moving negative
// RULE_14: Methods 26, 27 stop falling edge moving positive
// RULE_15: Method 35 no motion, present position is home
// RULE_16: Report status 9437 once homing found
// RULE_17: Unsupported method refuses start and flags error
// RULE_18: On stop load home position, hold done flag
module hms_sequencer
  import hms_pkg::*;
#(
  parameter int POS_W = 32 // Position counter width
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] method_sel,
  input wire logic start,
  input wire logic [POS_W-1:0] home_pos,
  input wire logic step_tick,
  input wire logic neg_limit,
  input wire logic pos_limit,
  input wire logic home_sw,
  output logic motor_run,
  output logic motor_dir,
  output logic busy,
  output logic home_done,
  output logic method_err,
  output logic [15:0] status_word,
  output logic [POS_W-1:0] position
);

  // Decode a method number into its search behaviour
  function automatic hms_cfg_s method_cfg(input logic [7:0] m);
    hms_cfg_s c;
    c = '0;
    case (m)
      HMS_M_NEG_LIM: begin // see RULE_02
        c.valid = 1'b1;
        c.lim_ref = 1'b1;
      end
      HMS_M_POS_LIM: begin // see RULE_03
        c.valid = 1'b1;
        c.lim_ref = 1'b1;
        c.init_pos = 1'b1;
      end
      HMS_M_19: c = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0}; // see RULE_04 see RULE_05
      HMS_M_20: c = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0}; // see RULE_04 see RULE_06
      HMS_M_21: c = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0}; // see RULE_04 see RULE_05
      HMS_M_22: c = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0}; // see RULE_04 see RULE_06
      HMS_M_23: c = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0}; // see RULE_07 see RULE_11
      HMS_M_24: c = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1}; // see RULE_07 see RULE_12
      HMS_M_25: c = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0}; // see RULE_07 see RULE_13
      HMS_M_26: c = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1}; // see RULE_07 see RULE_14
      HMS_M_27: c = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1}; // see RULE_09 see RULE_14
      HMS_M_28: c = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0}; // see RULE_09 see RULE_13
      HMS_M_29: c = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1}; // see RULE_09 see RULE_12
      HMS_M_30: c = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0}; // see RULE_09 see RULE_11
      HMS_M_HERE: begin // see RULE_15
        c.valid = 1'b1;
        c.no_move = 1'b1;
      end
      default: c = '0; // Anything else is unsupported, see RULE_01
    endcase
    return c;
  endfunction : method_cfg

  // Filtered switch levels
  logic neg_lvl;
  logic pos_lvl;
  logic home_lvl;

  hms_in_sync u_sync_neg (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pin_in(neg_limit),
    .level_out(neg_lvl)
  );
  hms_in_sync u_sync_pos (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pin_in(pos_limit),
    .level_out(pos_lvl)
  );
  hms_in_sync u_sync_home (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pin_in(home_sw),
    .level_out(home_lvl)
  );

  // Sequencer state
  hms_state_e state_reg, state_next;
  hms_cfg_s cfg_reg, cfg_next; // Method latched at start
  logic dir_reg, dir_next; // Present travel direction
  logic done_reg, done_next; // Homing complete flag
  logic err_reg, err_next; // Bad method flag
  logic [15:0] stat_reg, stat_next; // Status word to host
  logic [POS_W-1:0] pos_reg, pos_next; // Position counter
  logic [2:0] prev_reg, prev_next; // Last levels: home, pos, neg

  // Edge and limit terms derived from the filtered levels
  logic home_rise;
  logic home_fall;
  logic lim_ahead; // Limit in the direction of travel is active
  logic lim_ahead_fall; // That limit just went inactive
  logic stop_hit;

  always_comb begin
    home_rise = home_lvl & ~prev_reg[2];
    home_fall = ~home_lvl & prev_reg[2];
    lim_ahead = (dir_reg == HMS_DIR_POS) ? pos_lvl : neg_lvl;
    lim_ahead_fall = (dir_reg == HMS_DIR_POS) ? (~pos_lvl & prev_reg[1])
                                              : (~neg_lvl & prev_reg[0]);
    // Switch edge of the right kind, in the right direction if it matters
    stop_hit = (cfg_reg.rise ? home_rise : home_fall) &
               (~cfg_reg.dir_chk | (dir_reg == cfg_reg.need_pos)); // see RULE_11 see RULE_12
  end

  // Next-state logic for the sequencer
  always_comb begin
    state_next = state_reg;
    cfg_next = cfg_reg;
    dir_next = dir_reg;
    done_next = done_reg;
    err_next = err_reg;
    stat_next = stat_reg;
    pos_next = pos_reg;
    prev_next = {home_lvl, pos_lvl, neg_lvl};
    // Count steps while the motor runs
    if ((state_reg == HMS_SEARCH) && step_tick) begin
      pos_next = (dir_reg == HMS_DIR_POS) ? pos_reg + POS_W'(1) : pos_reg - POS_W'(1);
    end
    case (state_reg)
      HMS_IDLE, HMS_DONE, HMS_ERROR: begin
        if (start) begin
          // Done is held until the next start, see RULE_18
          done_next = 1'b0;
          stat_next = HMS_STAT_OTHER;
          cfg_next = method_cfg(method_sel);
          if (!method_cfg(method_sel).valid) begin
            state_next = HMS_ERROR; // Refuse without motion, see RULE_17
            err_next = 1'b1;
          end else if (method_cfg(method_sel).no_move) begin
            state_next = HMS_DONE; // Present position is home, see RULE_15
            pos_next = home_pos;
            done_next = 1'b1;
            err_next = 1'b0;
            stat_next = HMS_STAT_FOUND; // see RULE_16
          end else begin
            state_next = HMS_SEARCH;
            err_next = 1'b0;
            dir_next = method_cfg(method_sel).init_pos; // see RULE_04 see RULE_07 see RULE_09
          end
        end
      end
      HMS_SEARCH: begin
        if (cfg_reg.lim_ref) begin
          // Limit methods: run into the limit, back off, home where it releases
          if (lim_ahead && (dir_reg == cfg_reg.init_pos)) begin
            dir_next = ~dir_reg; // see RULE_02 see RULE_03
          end else if ((dir_reg != cfg_reg.init_pos) &&
                       (cfg_reg.init_pos ? (~pos_lvl & prev_reg[1])
                                         : (~neg_lvl & prev_reg[0]))) begin
            state_next = HMS_DONE; // see RULE_02 see RULE_03
          end
        end else if (stop_hit) begin
          // Switch edge wins over a limit seen in the same cycle
          state_next = HMS_DONE; // see RULE_05 see RULE_06 see RULE_13 see RULE_14
        end else if (lim_ahead) begin
          // A limit in the travel direction turns the axis around
          dir_next = ~dir_reg; // see RULE_08 see RULE_10
        end
        if (state_next == HMS_DONE) begin
          pos_next = home_pos; // see RULE_18
          done_next = 1'b1;
          stat_next = HMS_STAT_FOUND; // see RULE_16
        end
      end
      default: state_next = HMS_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= HMS_IDLE;
      cfg_reg <= '0;
      dir_reg <= HMS_DIR_POS;
      done_reg <= 1'b0;
      err_reg <= 1'b0;
      stat_reg <= HMS_STAT_OTHER;
      pos_reg <= '0;
      prev_reg <= HMS_SYNC_RST;
    end else begin
      state_reg <= state_next;
      cfg_reg <= cfg_next;
      dir_reg <= dir_next;
      done_reg <= done_next;
      err_reg <= err_next;
      stat_reg <= stat_next;
      pos_reg <= pos_next;
      prev_reg <= prev_next;
    end
  end

  // Outputs; run and busy are decoded straight from state flops
  assign motor_run = (state_reg == HMS_SEARCH);
  assign busy = (state_reg == HMS_SEARCH);
  assign motor_dir = dir_reg;
  assign home_done = done_reg;
  assign method_err = err_reg;
  assign status_word = stat_reg;
  assign position = pos_reg;
endmodule : hms_sequencer
`default_nettype wire

// >>> hms_pkg.sv
// Constants and types shared by the homing sequencer files
package hms_pkg;
  // Supported method numbers
  localparam logic [7:0] HMS_M_NEG_LIM = 8'h11; // 17
  localparam logic [7:0] HMS_M_POS_LIM = 8'h12; // 18
  localparam logic [7:0] HMS_M_19 = 8'h13;
  localparam logic [7:0] HMS_M_20 = 8'h14;
  localparam logic [7:0] HMS_M_21 = 8'h15;
  localparam logic [7:0] HMS_M_22 = 8'h16;
  localparam logic [7:0] HMS_M_23 = 8'h17;
  localparam logic [7:0] HMS_M_24 = 8'h18;
  localparam logic [7:0] HMS_M_25 = 8'h19;
  localparam logic [7:0] HMS_M_26 = 8'h1A;
  localparam logic [7:0] HMS_M_27 = 8'h1B;
  localparam logic [7:0] HMS_M_28 = 8'h1C;
  localparam logic [7:0] HMS_M_29 = 8'h1D;
  localparam logic [7:0] HMS_M_30 = 8'h1E;
  localparam logic [7:0] HMS_M_HERE = 8'h23; // 35
  // Status word values seen by the host
  localparam logic [15:0] HMS_STAT_FOUND = 16'h24DD; // 9437
  localparam logic [15:0] HMS_STAT_OTHER = 16'h0000;
  // Travel direction encoding
  localparam logic HMS_DIR_POS = 1'b1;
  localparam logic HMS_DIR_NEG = 1'b0;
  // Reset values
  localparam logic [2:0] HMS_SYNC_RST = 3'h0;
  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    HMS_IDLE = 4'h1,
    HMS_SEARCH = 4'h2,
    HMS_DONE = 4'h4,
    HMS_ERROR = 4'h8
  } hms_state_e;
  // Decoded method behaviour
  typedef struct packed {
    logic valid;    // Method is supported
    logic no_move;  // Take present position
    logic lim_ref;  // A limit is the reference signal
    logic init_pos; // First move is positive
    logic rise;     // Stop edge is rising
    logic dir_chk;  // Stop edge only counts in one direction
    logic need_pos; // That direction is positive
  } hms_cfg_s;
endpackage : hms_pkg

// >>> hms_in_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module hms_in_sync
  import hms_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic pin_in,
  output logic level_out
);
  logic [2:0] chain_reg; // Bit 0 is only read by bit 1
  logic [2:0] chain_next;
  logic level_reg; // Accepted level
  logic level_next;

  // Shift the pin in; accept a new level once stages two and three agree
  always_comb begin
    chain_next = {chain_reg[1:0], pin_in};
    level_next = (chain_reg[1] == chain_reg[2]) ? chain_reg[2] : level_reg;
  end

  // Register only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      chain_reg <= HMS_SYNC_RST;
      level_reg <= 1'b0;
    end else begin
      chain_reg <= chain_next;
      level_reg <= level_next;
    end
  end

  assign level_out = level_reg;
endmodule : hms_in_sync
`default_nettype wire

// >>> hms_props.sv
// Port assertions for the homing sequencer
`timescale 1ns/100ps
`default_nettype none
module hms_props
  import hms_pkg::*;
#(
  parameter int POS_W = 32
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] method_sel,
  input wire logic start,
  input wire logic [POS_W-1:0] home_pos,
  input wire logic step_tick,
  input wire logic neg_limit,
  input wire logic pos_limit,
  input wire logic home_sw,
  input wire logic motor_run,
  input wire logic motor_dir,
  input wire logic busy,
  input wire logic home_done,
  input wire logic method_err,
  input wire logic [15:0] status_word,
  input wire logic [POS_W-1:0] position
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic go; // Start that the sequencer must take
  logic mv; // Method that moves the motor
  assign go = start && !busy;
  assign mv = method_sel inside {[8'h11:8'h1E]};
  property p_take; go && mv |=> busy && motor_run && !method_err; endproperty
  a_take: assert property (p_take) else $error("moving start not taken");
  property p_dpos; go && (method_sel inside {[8'h12:8'h14], [8'h17:8'h1A]}) |=> motor_dir;
  endproperty
  a_dpos: assert property (p_dpos) else $error("start not positive");
  property p_dneg; go && (method_sel inside {8'h11, 8'h15, 8'h16, [8'h1B:8'h1E]}) |=> !motor_dir;
  endproperty
  a_dneg: assert property (p_dneg) else $error("start not negative");
  property p_here; go && method_sel == 8'h23 |=> home_done && !busy && position == $past(home_pos);
  endproperty
  a_here: assert property (p_here) else $error("present position not taken");
  property p_bad; go && !mv && method_sel != 8'h23 |=> method_err && !busy && !home_done;
  endproperty
  a_bad: assert property (p_bad) else $error("bad method not refused");
  property p_stat; status_word == (home_done ? HMS_STAT_FOUND : HMS_STAT_OTHER); endproperty
  a_stat: assert property (p_stat) else $error("status word wrong");
  property p_load; $rose(home_done) |-> position == home_pos && !motor_run; endproperty
  a_load: assert property (p_load) else $error("home position not loaded");
  property p_hold; home_done && !start |=> home_done; endproperty
  a_hold: assert property (p_hold) else $error("done flag dropped");
  property p_still; !motor_run && !start |=> $stable(position); endproperty
  a_still: assert property (p_still) else $error("position moved at rest");
  // A positive limit held for five samples must have turned the motor round;
  // three filter stages, one level flop and one decision edge make up the five
  property p_rev; (motor_run && motor_dir && pos_limit) [*5] |=> !motor_run || !motor_dir;
  endproperty
  a_rev: assert property (p_rev) else $error("no reversal at limit");
  // Same budget on the negative side
  property p_revn; (motor_run && !motor_dir && neg_limit) [*5] |=> !motor_run || motor_dir;
  endproperty
  a_revn: assert property (p_revn) else $error("no reversal at negative limit");
  // Each step taken while running moves the counter one place along the travel direction
  property p_count; motor_run && step_tick |=> !motor_run ||
    ($past(motor_dir) ? position == POS_W'($past(position) + 32'h1)
                      : position == POS_W'($past(position) - 32'h1));
  endproperty
  a_count: assert property (p_count) else $error("step not counted");
endmodule : hms_props
bind hms_sequencer hms_props #(.POS_W(POS_W)) hms_props_i (.sys_clk(sys_clk), .rst_n(rst_n),
  .method_sel(method_sel), .start(start), .home_pos(home_pos), .step_tick(step_tick),
  .neg_limit(neg_limit), .pos_limit(pos_limit), .home_sw(home_sw), .motor_run(motor_run),
  .motor_dir(motor_dir), .busy(busy), .home_done(home_done), .method_err(method_err),
  .status_word(status_word), .position(position));
`default_nettype wire

// >>> hms_motor_model.sv
// Axis model: motor steps, limit switches and home switch
`timescale 1ns/100ps
`default_nettype none
module hms_motor_model (
  input wire logic sys_clk,
  input wire logic park,
  input wire logic motor_run,
  input wire logic motor_dir,
  output logic step_tick = 1'b0,
  output logic neg_limit,
  output logic pos_limit,
  output logic home_sw,
  output logic last_dir = 1'b1
);
  int x = 40; // Axis place, parked below the switch
  int ph = 0; // Slow pacing so a stop lands before the next step
  always @(negedge sys_clk) begin
    ph <= (ph + 1) % 8;
    step_tick <= (ph == 0) && motor_run;
    if (park) begin
      x <= 40;
    end else if (step_tick && motor_run) begin
      x <= motor_dir ? x + 1 : x - 1;
      last_dir <= motor_dir;
    end
  end
  assign neg_limit = x <= 0;
  assign pos_limit = x >= 200;
  assign home_sw = x >= 80 && x < 120;
endmodule : hms_motor_model
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the homing sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import hms_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] method_sel = 8'h00;
  logic start = 1'b0;
  logic [31:0] home_pos = 32'h0;
  logic park = 1'b1;
  logic step_tick, neg_limit, pos_limit, home_sw, last_dir;
  logic motor_run, motor_dir, busy, home_done, method_err;
  logic [15:0] status_word;
  logic [31:0] position;
  logic [31:0] lfsr = 32'h00012F17; // Random source, fixed start
  int mismatches = 0;
  int comparisons = 0;
  always #4 sys_clk = ~sys_clk;
  hms_sequencer hms_sequencer_i (.sys_clk(sys_clk), .rst_n(rst_n), .method_sel(method_sel),
    .start(start), .home_pos(home_pos), .step_tick(step_tick), .neg_limit(neg_limit),
    .pos_limit(pos_limit), .home_sw(home_sw), .motor_run(motor_run), .motor_dir(motor_dir),
    .busy(busy), .home_done(home_done), .method_err(method_err), .status_word(status_word),
    .position(position));
  hms_motor_model hms_motor_model_i (.sys_clk(sys_clk), .park(park), .motor_run(motor_run),
    .motor_dir(motor_dir), .step_tick(step_tick), .neg_limit(neg_limit),
    .pos_limit(pos_limit), .home_sw(home_sw), .last_dir(last_dir));
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt
  // Travel direction and switch level at home, starting below the switch
  function automatic logic [1:0] expect_stop(input logic [7:0] m);
    logic rise;
    logic dirp;
    rise = m inside {8'h14, 8'h16, 8'h18, 8'h19, 8'h1C, 8'h1D};
    dirp = !(m inside {8'h12, 8'h17, 8'h19, 8'h1C, 8'h1E});
    return {dirp, rise};
  endfunction : expect_stop
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish
  // Park the axis, start one method, wait for home or refusal
  task automatic run(input logic [7:0] m);
    int n;
    park <= 1'b1;
    repeat (8) @(negedge sys_clk);
    park <= 1'b0;
    home_pos <= lfsr;
    lfsr = nxt(lfsr);
    method_sel <= m;
    start <= 1'b1;
    @(negedge sys_clk);
    start <= 1'b0;
    n = 0;
    while (home_done !== 1'b1 && method_err !== 1'b1 && n < 6000) begin
      @(negedge sys_clk);
      n++;
    end
    if (n == 6000) begin
      mismatches++;
      tally_and_finish();
    end
  endtask : run
  initial begin
    logic [7:0] bad [6];
    bad = '{8'h00, 8'h10, 8'h1F, 8'h22, 8'h24, 8'h80};
    repeat (20) @(negedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      run(i < 6 ? bad[i] : {1'b1, lfsr[6:0]});
      check(32'(method_err), 32'h1);
      check(32'({busy, home_done}), 32'h0);
    end
    for (int m = 8'h11; m <= 8'h1E; m++) begin
      run(m[7:0]);
      check(32'({last_dir, home_sw}), 32'(expect_stop(m[7:0])));
      check(32'(method_err), 32'h0);
      check(position, home_pos);
      check(32'(status_word), 32'(HMS_STAT_FOUND));
    end
    run(8'h23);
    check(position, home_pos);
    check(32'({busy, home_done}), 32'h1);
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
